// *** hw/tpic_cfg.svh ***
`ifndef TPIC_CFG_SVH
`define TPIC_CFG_SVH
// register index on the plain port
`define TPIC_ADDR_LO_CTRL 3'h0
`define TPIC_ADDR_HI_CTRL 3'h1
`define TPIC_ADDR_CAP_CTRL 3'h2
`define TPIC_ADDR_CAP_BUF 3'h3
`define TPIC_ADDR_LO_COUNT 3'h4
`define TPIC_ADDR_HI_COUNT 3'h5
`define TPIC_ADDR_LO_PERIOD 3'h6
`define TPIC_ADDR_HI_PERIOD 3'h7
// timer control fields
`define TPIC_BIT_RUN 15
`define TPIC_BIT_IDLE_STOP 13
`define TPIC_BIT_GATE 6
`define TPIC_BIT_PS_HI 5
`define TPIC_BIT_PS_LO 4
`define TPIC_BIT_JOIN 3
`define TPIC_BIT_CLK_SRC 1
`define TPIC_LO_CTRL_MASK 16'hA07A
`define TPIC_HI_CTRL_MASK 16'hA072
// capture control fields
`define TPIC_BIT_CAP_IDLE 13
`define TPIC_BIT_CAP_TB 7
`define TPIC_BIT_CPI_HI 6
`define TPIC_BIT_CPI_LO 5
`define TPIC_BIT_CAP_OVF 4
`define TPIC_BIT_CAP_NE 3
`define TPIC_BIT_MODE_HI 2
`define TPIC_CAP_CTRL_MASK 16'h20E7
`define TPIC_CTRL_RESET 16'h0000
// prescale terminal counts
`define TPIC_PS_DIV1 8'h00
`define TPIC_PS_DIV8 8'h07
`define TPIC_PS_DIV64 8'h3F
`define TPIC_PS_DIV256 8'hFF
`define TPIC_EDGE4_LAST 4'h3
`define TPIC_EDGE16_LAST 4'hF
`define TPIC_PERIOD_RESET 16'hFFFF
`endif

// *** hw/tpic_pkg.sv ***
package tpic_pkg;
	typedef enum logic [2:0] {
		TPIC_CAP_OFF = 3'b000,
		TPIC_CAP_EVERY_EDGE = 3'b001,
		TPIC_CAP_FALL = 3'b010,
		TPIC_CAP_RISE = 3'b011,
		TPIC_CAP_RISE4 = 3'b100,
		TPIC_CAP_RISE16 = 3'b101,
		TPIC_CAP_UNUSED = 3'b110,
		TPIC_CAP_WAKE = 3'b111
	} tpic_cap_mode_t;
endpackage

// *** hw/tpic_timer_pair_capture.sv ***
// Function
// - run_enable starts and stops the timer; low control runs the joined pair.
// - idle_stop set halts the timer during Idle; clear keeps it running.
// - gated accumulation works only with internal clock; ignored with external clock.
// - prescale_select divides input clock by 1, 8, 64 or 256.
// - pair_join_select joins both timers into one 32-bit timer.
// - clock_source_select picks external pin rising edges or the internal clock.
// - in 32-bit mode high control bits have no effect on the timers.
// - unimplemented bits read zero; implemented control bits reset to zero.
// - each qualifying capture event stores the selected 16-bit count.
// - capture_timebase_select 1 captures low count, 0 captures high count.
// - capture_mode_select picks off, every edge, fall, rise, 4th or 16th rise.
// - mode 111 only wakes on rising edges in Sleep or Idle.
// - every-edge mode interrupts on each capture, ignoring captures_per_interrupt.
// - captures_per_interrupt gives an interrupt every 1, 2, 3 or 4 captures.
// - captured values are held in a four-entry first-in first-out buffer.
// - overflow flag set by hardware on overflow; software writes do nothing.
// - not-empty flag is high while any captured value remains unread.
// - capture_idle_stop set halts buffer captures during Idle; the mode 111 wake and interrupt still fire.
// - a capture pin event can wake the chip from Sleep or Idle.
// - the capture channel raises its interrupt at the set capture rate.
// - in 32-bit mode low timer holds low word, high timer high word.
// - in 32-bit mode low clock and gate drive the pair; high flag interrupts.
// - in 32-bit mode the interrupt fires when the count matches the period.
`timescale 1ns/100ps
`include "tpic_cfg.svh"
module tpic_timer_pair_capture
	import tpic_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	input wire logic low_word_ext_clock_pin,
	input wire logic high_word_ext_clock_pin,
	input wire logic low_gate_pin,
	input wire logic high_gate_pin,
	input wire logic capture_input_pin,
	output logic low_timer_irq,
	output logic high_timer_irq,
	output logic capture_irq,
	output logic wake_request
);
	localparam int PTR_W = $clog2(FIFO_DEPTH);

	initial begin
		if (FIFO_DEPTH != 4) begin
			$error("capture buffer depth must be 4");
		end
	end

	logic [15:0] low_ctrl_reg;
	logic [15:0] high_ctrl_reg;
	logic [15:0] cap_ctrl_reg;
	logic [15:0] low_count_reg;
	logic [15:0] high_count_reg;
	logic [15:0] low_period_reg;
	logic [15:0] high_period_reg;
	logic [1:0] ext_prev_reg;
	logic [1:0] gate_prev_reg;
	logic [7:0] ps_cnt_reg [2];
	logic cap_prev_reg;
	logic [3:0] edge_cnt_reg;
	logic [1:0] irq_cnt_reg;
	logic [15:0] fifo_mem_reg [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0] fill_reg;
	logic ovf_reg;

	logic joined;
	logic [1:0] tick;
	logic [1:0] match;
	logic [1:0] gate_fall;
	logic cap_rise;
	logic cap_fall;
	logic cap_run;
	logic cap_event;
	logic buf_read;
	logic buf_push;
	logic [15:0] cap_value;
	logic [1:0] irq_last;
	tpic_cap_mode_t cap_mode;

	assign joined = low_ctrl_reg[`TPIC_BIT_JOIN];
	assign cap_mode = tpic_cap_mode_t'(cap_ctrl_reg[`TPIC_BIT_MODE_HI:0]);

	// per-timer clocking: in joined mode both halves take the low control bits
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_tmr
			logic [15:0] ctl;
			logic ext_pin;
			logic gate_pin;
			logic src_edge;
			logic run;
			logic [7:0] ps_last;
			assign ctl = (gi == 0 || joined) ? low_ctrl_reg : high_ctrl_reg;
			assign ext_pin = (gi == 0 || joined) ? low_word_ext_clock_pin
				: high_word_ext_clock_pin;
			assign gate_pin = (gi == 0 || joined) ? low_gate_pin : high_gate_pin;
			assign run = ctl[`TPIC_BIT_RUN]
				&& !(cpu_idle && ctl[`TPIC_BIT_IDLE_STOP])
				&& !cpu_sleep;
			always_comb begin
				if (ctl[`TPIC_BIT_CLK_SRC]) begin
					src_edge = ext_pin && !ext_prev_reg[gi];
				end else if (ctl[`TPIC_BIT_GATE]) begin
					src_edge = gate_pin;
				end else begin
					src_edge = 1'b1;
				end
			end
			always_comb begin
				unique case (ctl[`TPIC_BIT_PS_HI:`TPIC_BIT_PS_LO])
					2'b00: ps_last = `TPIC_PS_DIV1;
					2'b01: ps_last = `TPIC_PS_DIV8;
					2'b10: ps_last = `TPIC_PS_DIV64;
					2'b11: ps_last = `TPIC_PS_DIV256;
				endcase
			end
			assign tick[gi] = run && src_edge && (ps_cnt_reg[gi] == ps_last);
			assign gate_fall[gi] = !ctl[`TPIC_BIT_CLK_SRC] && ctl[`TPIC_BIT_GATE]
				&& gate_prev_reg[gi] && !gate_pin;
			always_ff @(posedge core_clk) begin
				if (sys_rst || !run) begin
					ps_cnt_reg[gi] <= `TPIC_PS_DIV1;
				end else if (src_edge) begin
					ps_cnt_reg[gi] <= (ps_cnt_reg[gi] == ps_last) ? `TPIC_PS_DIV1
						: ps_cnt_reg[gi] + 8'h01;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ext_prev_reg <= 2'b00;
			gate_prev_reg <= 2'b00;
			cap_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= {high_word_ext_clock_pin, low_word_ext_clock_pin};
			gate_prev_reg <= {high_gate_pin, low_gate_pin};
			cap_prev_reg <= capture_input_pin;
		end
	end

	// period match; joined mode compares all 32 bits
	assign match[0] = (low_count_reg == low_period_reg);
	assign match[1] = joined ? (match[0] && high_count_reg == high_period_reg)
		: (high_count_reg == high_period_reg);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			low_count_reg <= `TPIC_CTRL_RESET;
			high_count_reg <= `TPIC_CTRL_RESET;
		end else if (reg_write && reg_addr == `TPIC_ADDR_LO_COUNT) begin
			low_count_reg <= reg_wdata;
		end else if (reg_write && reg_addr == `TPIC_ADDR_HI_COUNT) begin
			high_count_reg <= reg_wdata;
		end else if (joined) begin
			if (tick[0]) begin
				if (match[1]) begin
					low_count_reg <= `TPIC_CTRL_RESET;
					high_count_reg <= `TPIC_CTRL_RESET;
				end else begin
					low_count_reg <= low_count_reg + 16'h0001;
					if (low_count_reg == `TPIC_PERIOD_RESET) begin
						high_count_reg <= high_count_reg + 16'h0001;
					end
				end
			end
		end else begin
			if (tick[0]) begin
				low_count_reg <= match[0] ? `TPIC_CTRL_RESET : low_count_reg + 16'h0001;
			end
			if (tick[1]) begin
				high_count_reg <= match[1] ? `TPIC_CTRL_RESET : high_count_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			low_timer_irq <= 1'b0;
			high_timer_irq <= 1'b0;
		end else begin
			low_timer_irq <= !joined && ((tick[0] && match[0]) || gate_fall[0]);
			high_timer_irq <= joined ? ((tick[0] && match[1]) || gate_fall[0])
				: ((tick[1] && match[1]) || gate_fall[1]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			low_period_reg <= `TPIC_PERIOD_RESET;
			high_period_reg <= `TPIC_PERIOD_RESET;
		end else if (reg_write && reg_addr == `TPIC_ADDR_LO_PERIOD) begin
			low_period_reg <= reg_wdata;
		end else if (reg_write && reg_addr == `TPIC_ADDR_HI_PERIOD) begin
			high_period_reg <= reg_wdata;
		end
	end

	// control registers; only implemented bits are stored
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			low_ctrl_reg <= `TPIC_CTRL_RESET;
			high_ctrl_reg <= `TPIC_CTRL_RESET;
			cap_ctrl_reg <= `TPIC_CTRL_RESET;
		end else if (reg_write) begin
			if (reg_addr == `TPIC_ADDR_LO_CTRL) begin
				low_ctrl_reg <= reg_wdata & `TPIC_LO_CTRL_MASK;
			end
			if (reg_addr == `TPIC_ADDR_HI_CTRL) begin
				high_ctrl_reg <= reg_wdata & `TPIC_HI_CTRL_MASK;
			end
			if (reg_addr == `TPIC_ADDR_CAP_CTRL) begin
				cap_ctrl_reg <= reg_wdata & `TPIC_CAP_CTRL_MASK;
			end
		end
	end

	// capture event qualification
	assign cap_rise = capture_input_pin && !cap_prev_reg;
	assign cap_fall = !capture_input_pin && cap_prev_reg;
	assign cap_run = !(cpu_idle && cap_ctrl_reg[`TPIC_BIT_CAP_IDLE])
		&& !cpu_sleep;

	always_comb begin
		unique case (cap_mode)
			TPIC_CAP_EVERY_EDGE: cap_event = cap_rise || cap_fall;
			TPIC_CAP_FALL: cap_event = cap_fall;
			TPIC_CAP_RISE: cap_event = cap_rise;
			TPIC_CAP_RISE4: cap_event = cap_rise && edge_cnt_reg == `TPIC_EDGE4_LAST;
			TPIC_CAP_RISE16: cap_event = cap_rise && edge_cnt_reg == `TPIC_EDGE16_LAST;
			TPIC_CAP_OFF, TPIC_CAP_UNUSED, TPIC_CAP_WAKE: cap_event = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || cap_mode == TPIC_CAP_OFF) begin
			edge_cnt_reg <= 4'h0;
		end else if (cap_run && cap_rise
			&& (cap_mode == TPIC_CAP_RISE4 || cap_mode == TPIC_CAP_RISE16)) begin
			edge_cnt_reg <= (cap_event) ? 4'h0 : edge_cnt_reg + 4'h1;
		end
	end

	assign cap_value = cap_ctrl_reg[`TPIC_BIT_CAP_TB] ? low_count_reg
		: high_count_reg;
	assign buf_read = reg_read && reg_addr == `TPIC_ADDR_CAP_BUF && fill_reg != '0;
	assign buf_push = cap_run && cap_event;

	// four-entry buffer; a capture into a full buffer is dropped and flags overflow
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fill_reg <= '0;
			ovf_reg <= 1'b0;
		end else begin
			if (buf_push && fill_reg != (PTR_W+1)'(FIFO_DEPTH)) begin
				fifo_mem_reg[wr_ptr_reg] <= cap_value;
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (buf_read) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (buf_push && fill_reg != (PTR_W+1)'(FIFO_DEPTH) && !buf_read) begin
				fill_reg <= fill_reg + 1'b1;
			end else if (buf_read && (!buf_push || fill_reg == (PTR_W+1)'(FIFO_DEPTH))) begin
				fill_reg <= fill_reg - 1'b1;
			end
			// a dropped capture always flags, even when a read frees a slot in that cycle
			if (buf_push && fill_reg == (PTR_W+1)'(FIFO_DEPTH)) begin
				ovf_reg <= 1'b1;
			end else if (buf_read || cap_mode == TPIC_CAP_OFF) begin
				ovf_reg <= 1'b0;
			end
		end
	end

	// capture interrupt rate
	assign irq_last = cap_ctrl_reg[`TPIC_BIT_CPI_HI:`TPIC_BIT_CPI_LO];
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_cnt_reg <= 2'b00;
			capture_irq <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			capture_irq <= 1'b0;
			wake_request <= 1'b0;
			if (cap_mode == TPIC_CAP_OFF) begin
				irq_cnt_reg <= 2'b00;
			end else if (cap_mode == TPIC_CAP_WAKE) begin
				if (cap_rise && (cpu_sleep || cpu_idle)) begin
					capture_irq <= 1'b1;
					wake_request <= 1'b1;
				end
			end else if (buf_push) begin
				if (cap_mode == TPIC_CAP_EVERY_EDGE || irq_cnt_reg == irq_last) begin
					capture_irq <= 1'b1;
					irq_cnt_reg <= 2'b00;
				end else begin
					irq_cnt_reg <= irq_cnt_reg + 2'b01;
				end
			end
		end
	end

	// read port: data in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_read) begin
			unique case (reg_addr)
				`TPIC_ADDR_LO_CTRL: reg_rdata <= low_ctrl_reg;
				`TPIC_ADDR_HI_CTRL: reg_rdata <= high_ctrl_reg;
				`TPIC_ADDR_CAP_CTRL: reg_rdata <= cap_ctrl_reg
					| {11'h000, ovf_reg, (fill_reg != '0), 3'b000};
				`TPIC_ADDR_CAP_BUF: reg_rdata <= (fill_reg != '0)
					? fifo_mem_reg[rd_ptr_reg] : 16'h0000;
				`TPIC_ADDR_LO_COUNT: reg_rdata <= low_count_reg;
				`TPIC_ADDR_HI_COUNT: reg_rdata <= high_count_reg;
				`TPIC_ADDR_LO_PERIOD: reg_rdata <= low_period_reg;
				`TPIC_ADDR_HI_PERIOD: reg_rdata <= high_period_reg;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule

// *** sim/tpic_monitor.sv ***
`timescale 1ns/100ps
module tpic_monitor
	import tpic_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	input wire logic low_timer_irq,
	input wire logic wake_request
);
	logic [15:0] lo_sh, hi_sh, cap_sh;
	// shadow copies of the writable control bits
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lo_sh <= 16'h0000;
			hi_sh <= 16'h0000;
			cap_sh <= 16'h0000;
		end else if (reg_write) begin
			if (reg_addr == 3'h0)
				lo_sh <= reg_wdata & 16'hA07A;
			if (reg_addr == 3'h1)
				hi_sh <= reg_wdata & 16'hA072;
			if (reg_addr == 3'h2)
				cap_sh <= reg_wdata & 16'h20E7;
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_lo_quiet;
		!low_timer_irq [*8];
	endsequence
	property p_rdata_idle;
		!$past(reg_read) |-> reg_rdata == 16'h0000;
	endproperty
	property p_lo_rd;
		$past(reg_read && reg_addr == 3'h0) |-> reg_rdata == $past(lo_sh);
	endproperty
	property p_hi_rd;
		$past(reg_read && reg_addr == 3'h1) |-> reg_rdata == $past(hi_sh);
	endproperty
	property p_cap_rd;
		$past(reg_read && reg_addr == 3'h2) |-> (reg_rdata & 16'hFFE7) == $past(cap_sh);
	endproperty
	property p_wake_pulse;
		wake_request |=> !wake_request;
	endproperty
	property p_wake_cause;
		wake_request |-> $past((cpu_sleep || cpu_idle) && cap_sh[2:0] == 3'h7);
	endproperty
	property p_join_quiet;
		lo_sh[3] && $past(lo_sh[3]) |-> !low_timer_irq;
	endproperty
	property p_div256;
		low_timer_irq && lo_sh[6] == 1'b0 && lo_sh[3] == 1'b0 && lo_sh[1] == 1'b0
			&& lo_sh[5:4] == 2'h3 |=> s_lo_quiet;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside a read");
	a_lo_rd: assert property (p_lo_rd)
		else $error("low control read back wrong");
	a_hi_rd: assert property (p_hi_rd)
		else $error("high control read back wrong");
	a_cap_rd: assert property (p_cap_rd)
		else $error("capture control read back wrong");
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("wake request longer than one cycle");
	a_wake_cause: assert property (p_wake_cause)
		else $error("wake request without sleep or wake mode");
	a_join_quiet: assert property (p_join_quiet)
		else $error("low irq while joined");
	a_div256: assert property (p_div256)
		else $error("low irq too soon at divide 256");
endmodule

// *** sim/tpic_edge_model.sv ***
`timescale 1ns/100ps
module tpic_edge_model (
	input wire logic core_clk,
	output logic cap_pin,
	output logic ext_ck
);
	initial begin
		cap_pin = 1'b0;
		ext_ck = 1'b0;
	end
	// each pulse is high two cycles then low two, so every edge is seen
	task automatic pulse(input bit on_cap, input int n);
		repeat (n) begin
			@(posedge core_clk);
			if (on_cap)
				cap_pin <= 1'b1;
			else
				ext_ck <= 1'b1;
			repeat (2) @(posedge core_clk);
			cap_pin <= 1'b0;
			ext_ck <= 1'b0;
			@(posedge core_clk);
		end
	endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/100ps
bind tpic_timer_pair_capture tpic_monitor i_mon (.core_clk(core_clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
	.low_timer_irq(low_timer_irq), .wake_request(wake_request));
module tb;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic cpu_idle = 1'b0;
	logic cpu_sleep = 1'b0;
	logic gate_lo = 1'b0;
	logic [15:0] reg_rdata, rv, rw;
	logic cap_pin, ext_ck, low_timer_irq, high_timer_irq, capture_irq, wake_request;
	int mismatches = 0, total_checks = 0, cyc = 0;
	int lo_last, lo_gap, hi_last, hi_gap, lo_cnt, cap_irqs, wake_cnt;
	always #50 core_clk = ~core_clk;
	tpic_edge_model i_edge (.core_clk(core_clk), .cap_pin(cap_pin), .ext_ck(ext_ck));
	tpic_timer_pair_capture i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .low_word_ext_clock_pin(ext_ck),
		.high_word_ext_clock_pin(1'b0), .low_gate_pin(gate_lo), .high_gate_pin(1'b0),
		.capture_input_pin(cap_pin), .low_timer_irq(low_timer_irq),
		.high_timer_irq(high_timer_irq), .capture_irq(capture_irq), .wake_request(wake_request));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// outputs are settled at the falling edge
	always @(negedge core_clk) begin
		cyc++;
		if (low_timer_irq === 1'b1) begin
			lo_gap = cyc - lo_last;
			lo_last = cyc;
			lo_cnt++;
		end
		if (high_timer_irq === 1'b1) begin
			hi_gap = cyc - hi_last;
			hi_last = cyc;
		end
		if (capture_irq === 1'b1)
			cap_irqs++;
		if (wake_request === 1'b1)
			wake_cnt++;
		if (cyc == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// capture run that drains the buffer after every pulse
	task automatic caps(input logic [15:0] ctrl, input int n, input int exp);
		wr(3'h2, 16'h0000);
		cap_irqs = 0;
		wr(3'h2, ctrl);
		repeat (n) begin
			i_edge.pulse(1'b1, 1);
			rd(3'h3, rv);
			rd(3'h3, rv);
		end
		w(4);
		chk("capture irq count", exp, cap_irqs);
	endtask
	task automatic t_regs();
		logic [15:0] rst [8] = '{0, 0, 0, 0, 0, 0, 16'hFFFF, 16'hFFFF};
		logic [15:0] m [3] = '{16'hA07A, 16'hA072, 16'h20E7};
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), rv);
			chk("reset value", rst[a], rv);
		end
		for (int a = 0; a < 3; a++) begin
			wr(3'(a), 16'hFFFF);
			rd(3'(a), rv);
			wr(3'(a), 16'h0000);
			chk("control read back", m[a], rv);
		end
	endtask
	task automatic t_timer();
		int dv [4] = '{1, 8, 64, 256};
		wr(3'h6, 16'h0003);
		for (int p = 0; p < 4; p++) begin
			wr(3'h4, 16'h0000);
			wr(3'h0, 16'h8000 | 16'(p << 4));
			w(8 * dv[p] + 20);
			wr(3'h0, 16'h0000);
			chk("low irq spacing", 4 * dv[p], lo_gap);
		end
		rd(3'h4, rv);
		w(20);
		rd(3'h4, rw);
		chk("stopped count", rv, rw);
		wr(3'h6, 16'hFFFF);
		wr(3'h0, 16'hA000);
		cpu_idle <= 1'b1;
		rd(3'h4, rv);
		w(10);
		rd(3'h4, rw);
		chk("idle halted count", rv, rw);
		wr(3'h0, 16'h8000);
		rd(3'h4, rv);
		w(10);
		rd(3'h4, rw);
		cpu_idle <= 1'b0;
		chk("idle running count", 16'h000C, rw - rv);
	endtask
	task automatic t_join();
		wr(3'h0, 16'h0000);
		wr(3'h4, 16'h0000);
		wr(3'h5, 16'h0000);
		wr(3'h6, 16'h0005);
		wr(3'h7, 16'h0000);
		wr(3'h1, 16'h0030);
		lo_cnt = 0;
		wr(3'h0, 16'h8008);
		w(40);
		chk("joined irq spacing", 6, hi_gap);
		chk("low irq while joined", 0, lo_cnt);
		wr(3'h0, 16'h0000);
		wr(3'h4, 16'hFFF0);
		wr(3'h7, 16'h0001);
		wr(3'h6, 16'hFFFF);
		wr(3'h0, 16'h8008);
		w(30);
		wr(3'h0, 16'h0000);
		rd(3'h5, rv);
		chk("high word count", 16'h0001, rv);
		wr(3'h4, 16'h0000);
		wr(3'h0, 16'h8042);
		i_edge.pulse(1'b0, 5);
		w(3);
		rd(3'h4, rv);
		wr(3'h0, 16'h0000);
		chk("external edge count", 16'h0005, rv);
		wr(3'h4, 16'h0000);
		lo_cnt = 0;
		wr(3'h0, 16'h8040);
		gate_lo <= 1'b1;
		w(10);
		gate_lo <= 1'b0;
		w(3);
		rd(3'h4, rv);
		wr(3'h0, 16'h0000);
		chk("gated count", 16'h000A, rv);
		chk("gate fall irq", 1, lo_cnt);
	endtask
	task automatic t_fifo();
		wr(3'h2, 16'h0083);
		for (int i = 0; i < 5; i++) begin
			wr(3'h4, 16'h1000 + 16'(i));
			i_edge.pulse(1'b1, 1);
		end
		wr(3'h2, 16'h0083);
		rd(3'h2, rv);
		chk("full status", 16'h009B, rv);
		for (int i = 0; i < 4; i++) begin
			rd(3'h3, rv);
			chk("buffer word", 16'h1000 + 16'(i), rv);
		end
		rd(3'h2, rv);
		chk("empty status", 16'h0083, rv);
		wr(3'h5, 16'h00AB);
		wr(3'h2, 16'h0003);
		i_edge.pulse(1'b1, 1);
		rd(3'h3, rv);
		chk("high base capture", 16'h00AB, rv);
	endtask
	task automatic t_modes();
		int ex [7] = '{0, 32, 16, 16, 4, 1, 0};
		for (int m = 0; m < 7; m++)
			caps(16'(m) | (m == 1 ? 16'h0060 : 16'h0000), 16, ex[m]);
		caps(16'h0004, 3, 0);
		caps(16'h0004, 2, 0);
		for (int k = 0; k < 4; k++)
			caps(16'h0003 | 16'(k << 5), 12, 12 / (k + 1));
	endtask
	task automatic t_sleep();
		wake_cnt = 0;
		wr(3'h2, 16'h0007);
		cpu_sleep <= 1'b1;
		i_edge.pulse(1'b1, 2);
		cpu_sleep <= 1'b0;
		i_edge.pulse(1'b1, 1);
		w(3);
		chk("wake pulses", 2, wake_cnt);
		caps(16'h2003, 0, 0);
		cpu_idle <= 1'b1;
		i_edge.pulse(1'b1, 2);
		cpu_idle <= 1'b0;
		w(3);
		chk("idle capture irq", 0, cap_irqs);
	endtask
	initial begin
		w(20);
		sys_rst <= 1'b0;
		t_regs();
		t_timer();
		t_join();
		t_fifo();
		t_modes();
		t_sleep();
		end_sim();
	end
endmodule
